// ===== inc/motion_regs_pkg.sv
// Register map, reset values and field positions of the motion sensor register bank
package motion_regs_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_GYRO_X_SELFTEST   = 8'h00;
   localparam logic [7:0] ADDR_GYRO_Y_SELFTEST   = 8'h01;
   localparam logic [7:0] ADDR_GYRO_Z_SELFTEST   = 8'h02;
   localparam logic [7:0] ADDR_ACCEL_X_SELFTEST  = 8'h0d;
   localparam logic [7:0] ADDR_ACCEL_Y_SELFTEST  = 8'h0e;
   localparam logic [7:0] ADDR_ACCEL_Z_SELFTEST  = 8'h0f;
   localparam logic [7:0] ADDR_GYRO_X_TRIM_HIGH  = 8'h13;
   localparam logic [7:0] ADDR_GYRO_X_TRIM_LOW   = 8'h14;
   localparam logic [7:0] ADDR_GYRO_Y_TRIM_HIGH  = 8'h15;
   localparam logic [7:0] ADDR_GYRO_Y_TRIM_LOW   = 8'h16;
   localparam logic [7:0] ADDR_MOTION_DETECT     = 8'h69;
   localparam logic [7:0] ADDR_HOST_CONTROL      = 8'h6a;
   localparam logic [7:0] ADDR_POWER_ONE         = 8'h6b;
   localparam logic [7:0] ADDR_POWER_TWO         = 8'h6c;
   localparam logic [7:0] ADDR_QUEUE_LEVEL_HIGH  = 8'h72;
   localparam logic [7:0] ADDR_QUEUE_LEVEL_LOW   = 8'h73;
   localparam logic [7:0] ADDR_QUEUE_DATA        = 8'h74;
   localparam logic [7:0] ADDR_DEVICE_IDENTITY   = 8'h75;
   localparam logic [7:0] ADDR_ACCEL_X_TRIM_HIGH = 8'h77;
   localparam logic [7:0] ADDR_ACCEL_X_TRIM_LOW  = 8'h78;
   localparam logic [7:0] ADDR_ACCEL_Y_TRIM_HIGH = 8'h7a;
   localparam logic [7:0] ADDR_ACCEL_Y_TRIM_LOW  = 8'h7b;
   localparam logic [7:0] ADDR_ACCEL_Z_TRIM_HIGH = 8'h7d;
   localparam logic [7:0] ADDR_ACCEL_Z_TRIM_LOW  = 8'h7e;

   // ----------------------------------------
   // Reset values and fields
   // ----------------------------------------
   localparam logic [7:0] RESET_VALUE_ZERO      = 8'h00;
   localparam logic [7:0] RESET_POWER_ONE       = 8'h40;
   localparam int         POWER_ONE_RESET_BIT   = 7;
   localparam int         POWER_ONE_SLEEP_BIT   = 6;
   localparam int         QUEUE_LEVEL_WIDTH     = 13;
   localparam int         SELFTEST_COUNT        = 6;
   localparam int         SELFTEST_INDEX_WIDTH  = 3;
   localparam int         ACCEL_TRIM_WIDTH      = 15;
   localparam int         GYRO_WIDTH            = 16;
endpackage

// ===== inc/selftest_if.sv
// Carrier between the register bank and the factory self-test code store
`timescale 1ns/10ps
interface selftest_if;
   logic                                              wrEn;
   logic [motion_regs_pkg::SELFTEST_INDEX_WIDTH-1:0] wrIndex;
   logic [7:0]                                        wrData;
   logic [motion_regs_pkg::SELFTEST_COUNT*8-1:0]     codes;

   modport bank  (output wrEn, output wrIndex, output wrData, input codes);
   modport store (input wrEn, input wrIndex, input wrData, output codes);
endinterface

// ===== rtl/selftest_code_store.sv
// Holds the six factory self-test codes, loaded after reset, host-writable
`timescale 1ns/10ps
module selftest_code_store #(
   parameter int COUNT = motion_regs_pkg::SELFTEST_COUNT
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   // Factory programmed values
   input  wire logic [COUNT*8-1:0] factoryCodes,
   // Bank side
   selftest_if.store          port
);
   logic [COUNT*8-1:0] codes_r;
   logic [COUNT*8-1:0] codes_nxt;
   logic               loaded_r;
   logic               loaded_nxt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      codes_nxt  = codes_r;
      loaded_nxt = 1'b1;
      // Codes caught after release, never under the async reset
      if (!loaded_r) begin
         codes_nxt = factoryCodes;
      end
      // Host write wins over the load in the same cycle
      if (port.wrEn && (32'(port.wrIndex) < COUNT)) begin
         codes_nxt[port.wrIndex*8 +: 8] = port.wrData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         codes_r  <= '0;
         loaded_r <= 1'b0;
      end else begin
         codes_r  <= codes_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   assign port.codes = codes_r;
endmodule

// ===== rtl/gyro_trim_adder.sv
// Adds a signed user trim to one raw gyroscope axis and holds the result
`timescale 1ns/10ps
module gyro_trim_adder #(
   parameter int WIDTH = motion_regs_pkg::GYRO_WIDTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Sample in
   input  wire logic             sampleValid,
   input  wire logic [WIDTH-1:0] rawValue,
   input  wire logic [WIDTH-1:0] trimValue,
   // Corrected sample out
   output logic      [WIDTH-1:0] outValue
);
   logic [WIDTH-1:0] out_r;
   logic [WIDTH-1:0] out_nxt;

   always_comb begin
      out_nxt = out_r;
      // Two's complement sum wraps like the sensor register does
      if (sampleValid) begin
         out_nxt = WIDTH'(rawValue + trimValue);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_r <= '0;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign outValue = out_r;
endmodule

// ===== rtl/motion_sensor_register_bank.sv
// Host register bank of the motion sensor: control, queue port, identity and trims
//
// Functional notes
// - Multi-byte values: high byte in the _high register, low byte in _low.
// - Everything resets to zero except power control one (0x40), identity, self-test codes.
// - Self-test registers come up holding factory values, not zero.
// - Six self-test registers each show an eight-bit factory code.
// - Device starts asleep and stays asleep until host changes power settings.
// - Signed gyro trim is added to the raw axis before the output register.
// - Gyro X and Y trims: first byte holds bits 15..8, second 7..0.
`timescale 1ns/10ps
module motion_sensor_register_bank #(
   parameter logic [7:0] DEVICE_ID = 8'h5a   // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Serial register access
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [7:0]  regWriteData,
   output logic      [7:0]  regReadData,
   output logic             regReadValid,
   // Factory programmed self-test codes
   input  wire logic [47:0] factoryCodes,
   // Queue side
   input  wire logic [12:0] queueLevel,
   input  wire logic [7:0]  queueReadData,
   output logic             queuePop,
   output logic             queuePush,
   output logic      [7:0]  queuePushData,
   // Gyro samples
   input  wire logic        gyroSampleValid,
   input  wire logic [15:0] gyroXRaw,
   input  wire logic [15:0] gyroYRaw,
   output logic      [15:0] gyroXOut,
   output logic      [15:0] gyroYOut,
   // Control outputs
   output logic      [7:0]  motionDetectCtrl,
   output logic      [7:0]  hostCtrl,
   output logic      [7:0]  powerOne,
   output logic      [7:0]  powerTwo,
   output logic             sleepMode,
   output logic      [47:0] selftestCodes,
   output logic      [14:0] accelXTrim,
   output logic      [14:0] accelYTrim,
   output logic      [14:0] accelZTrim
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [7:0]  motion_r;
   logic [7:0]  motion_nxt;
   logic [7:0]  host_r;
   logic [7:0]  host_nxt;
   logic [7:0]  pwrOne_r;
   logic [7:0]  pwrOne_nxt;
   logic [7:0]  pwrTwo_r;
   logic [7:0]  pwrTwo_nxt;

   logic [15:0] gyroXTrim_r;
   logic [15:0] gyroXTrim_nxt;
   logic [15:0] gyroYTrim_r;
   logic [15:0] gyroYTrim_nxt;
   logic [14:0] accX_r;
   logic [14:0] accX_nxt;
   logic [14:0] accY_r;
   logic [14:0] accY_nxt;
   logic [14:0] accZ_r;
   logic [14:0] accZ_nxt;

   logic [7:0]  rdData_r;
   logic [7:0]  rdData_nxt;
   logic        rdValid_r;
   logic        rdValid_nxt;
   logic        pop_r;
   logic        pop_nxt;
   logic        push_r;
   logic        push_nxt;
   logic [7:0]  pushData_r;
   logic [7:0]  pushData_nxt;

   logic [7:0]  readMux;
   logic        softReset;

   // Factory code store, loaded once after reset release
   selftest_if stIf ();

   selftest_code_store #(
      .COUNT (motion_regs_pkg::SELFTEST_COUNT)
   ) u_selftest (
      .clk          (clk),
      .rst_b        (rst_b),
      .factoryCodes (factoryCodes),
      .port         (stIf.store)
   );

   // ----------------------------------------
   // Self-test write path
   // ----------------------------------------
   // six factory code registers mapped to store slots
   always_comb begin
      // Soft reset cycle drops self-test writes like all others
      stIf.wrEn    = regWrite && !softReset;
      stIf.wrData  = regWriteData;
      stIf.wrIndex = 3'h7;
      unique case (regAddr)
         motion_regs_pkg::ADDR_GYRO_X_SELFTEST:  stIf.wrIndex = 3'h0;
         motion_regs_pkg::ADDR_GYRO_Y_SELFTEST:  stIf.wrIndex = 3'h1;
         motion_regs_pkg::ADDR_GYRO_Z_SELFTEST:  stIf.wrIndex = 3'h2;
         motion_regs_pkg::ADDR_ACCEL_X_SELFTEST: stIf.wrIndex = 3'h3;
         motion_regs_pkg::ADDR_ACCEL_Y_SELFTEST: stIf.wrIndex = 3'h4;
         motion_regs_pkg::ADDR_ACCEL_Z_SELFTEST: stIf.wrIndex = 3'h5;
         default:                                stIf.wrIndex = 3'h7;
      endcase
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // high suffix carries the upper bits of each wide value
   always_comb begin
      unique case (regAddr)
         motion_regs_pkg::ADDR_GYRO_X_SELFTEST:   readMux = stIf.codes[7:0];
         motion_regs_pkg::ADDR_GYRO_Y_SELFTEST:   readMux = stIf.codes[15:8];
         motion_regs_pkg::ADDR_GYRO_Z_SELFTEST:   readMux = stIf.codes[23:16];
         motion_regs_pkg::ADDR_ACCEL_X_SELFTEST:  readMux = stIf.codes[31:24];
         motion_regs_pkg::ADDR_ACCEL_Y_SELFTEST:  readMux = stIf.codes[39:32];
         motion_regs_pkg::ADDR_ACCEL_Z_SELFTEST:  readMux = stIf.codes[47:40];
         motion_regs_pkg::ADDR_GYRO_X_TRIM_HIGH:  readMux = gyroXTrim_r[15:8];
         motion_regs_pkg::ADDR_GYRO_X_TRIM_LOW:   readMux = gyroXTrim_r[7:0];
         motion_regs_pkg::ADDR_GYRO_Y_TRIM_HIGH:  readMux = gyroYTrim_r[15:8];
         motion_regs_pkg::ADDR_GYRO_Y_TRIM_LOW:   readMux = gyroYTrim_r[7:0];
         motion_regs_pkg::ADDR_MOTION_DETECT:     readMux = motion_r;
         motion_regs_pkg::ADDR_HOST_CONTROL:      readMux = host_r;
         motion_regs_pkg::ADDR_POWER_ONE:         readMux = pwrOne_r;
         motion_regs_pkg::ADDR_POWER_TWO:         readMux = pwrTwo_r;
         motion_regs_pkg::ADDR_QUEUE_LEVEL_HIGH:  readMux = {3'h0, queueLevel[12:8]};
         motion_regs_pkg::ADDR_QUEUE_LEVEL_LOW:   readMux = queueLevel[7:0];
         // Queue byte is registered like the others; the pop pulse comes out in the same cycle as the answer
         motion_regs_pkg::ADDR_QUEUE_DATA:        readMux = queueReadData;
         motion_regs_pkg::ADDR_DEVICE_IDENTITY:   readMux = DEVICE_ID;
         // Unused lowest bit of each accel low byte reads zero
         motion_regs_pkg::ADDR_ACCEL_X_TRIM_HIGH: readMux = accX_r[14:7];
         motion_regs_pkg::ADDR_ACCEL_X_TRIM_LOW:  readMux = {accX_r[6:0], 1'b0};
         motion_regs_pkg::ADDR_ACCEL_Y_TRIM_HIGH: readMux = accY_r[14:7];
         motion_regs_pkg::ADDR_ACCEL_Y_TRIM_LOW:  readMux = {accY_r[6:0], 1'b0};
         motion_regs_pkg::ADDR_ACCEL_Z_TRIM_HIGH: readMux = accZ_r[14:7];
         motion_regs_pkg::ADDR_ACCEL_Z_TRIM_LOW:  readMux = {accZ_r[6:0], 1'b0};
         default:                                 readMux = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Register next state
   // ----------------------------------------
   // Self-clearing device reset bit returns the control and trim registers to reset values, while the self-test codes keep their contents
   assign softReset = pwrOne_r[motion_regs_pkg::POWER_ONE_RESET_BIT];

   always_comb begin
      motion_nxt    = motion_r;
      host_nxt      = host_r;
      pwrOne_nxt    = pwrOne_r;
      pwrTwo_nxt    = pwrTwo_r;
      gyroXTrim_nxt = gyroXTrim_r;
      gyroYTrim_nxt = gyroYTrim_r;
      accX_nxt      = accX_r;
      accY_nxt      = accY_r;
      accZ_nxt      = accZ_r;
      push_nxt      = 1'b0;
      pushData_nxt  = pushData_r;
      pop_nxt       = regRead && (regAddr == motion_regs_pkg::ADDR_QUEUE_DATA);
      // one byte answered per addressed read
      rdValid_nxt   = regRead;
      rdData_nxt    = regRead ? readMux : rdData_r;
      // Reset wins over a write landing in the same cycle
      if (softReset) begin
         motion_nxt    = motion_regs_pkg::RESET_VALUE_ZERO;
         host_nxt      = motion_regs_pkg::RESET_VALUE_ZERO;
         pwrOne_nxt    = motion_regs_pkg::RESET_POWER_ONE;
         pwrTwo_nxt    = motion_regs_pkg::RESET_VALUE_ZERO;
         gyroXTrim_nxt = '0;
         gyroYTrim_nxt = '0;
         accX_nxt      = '0;
         accY_nxt      = '0;
         accZ_nxt      = '0;
      end else if (regWrite) begin
         // read-only offsets fall to default and store nothing
         unique case (regAddr)
            // trim high byte bits 15..8, low byte bits 7..0
            motion_regs_pkg::ADDR_GYRO_X_TRIM_HIGH:  gyroXTrim_nxt[15:8] = regWriteData;
            motion_regs_pkg::ADDR_GYRO_X_TRIM_LOW:   gyroXTrim_nxt[7:0]  = regWriteData;
            motion_regs_pkg::ADDR_GYRO_Y_TRIM_HIGH:  gyroYTrim_nxt[15:8] = regWriteData;
            motion_regs_pkg::ADDR_GYRO_Y_TRIM_LOW:   gyroYTrim_nxt[7:0]  = regWriteData;
            motion_regs_pkg::ADDR_MOTION_DETECT:     motion_nxt          = regWriteData;
            motion_regs_pkg::ADDR_HOST_CONTROL:      host_nxt            = regWriteData;
            // sleep left only by a host write here
            motion_regs_pkg::ADDR_POWER_ONE:         pwrOne_nxt          = regWriteData;
            motion_regs_pkg::ADDR_POWER_TWO:         pwrTwo_nxt          = regWriteData;
            motion_regs_pkg::ADDR_QUEUE_DATA: begin
               push_nxt     = 1'b1;
               pushData_nxt = regWriteData;
            end
            motion_regs_pkg::ADDR_ACCEL_X_TRIM_HIGH: accX_nxt[14:7]      = regWriteData;
            motion_regs_pkg::ADDR_ACCEL_X_TRIM_LOW:  accX_nxt[6:0]       = regWriteData[7:1];
            motion_regs_pkg::ADDR_ACCEL_Y_TRIM_HIGH: accY_nxt[14:7]      = regWriteData;
            motion_regs_pkg::ADDR_ACCEL_Y_TRIM_LOW:  accY_nxt[6:0]       = regWriteData[7:1];
            motion_regs_pkg::ADDR_ACCEL_Z_TRIM_HIGH: accZ_nxt[14:7]      = regWriteData;
            motion_regs_pkg::ADDR_ACCEL_Z_TRIM_LOW:  accZ_nxt[6:0]       = regWriteData[7:1];
            default:                                 ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         motion_r    <= motion_regs_pkg::RESET_VALUE_ZERO;
         host_r      <= motion_regs_pkg::RESET_VALUE_ZERO;
         pwrOne_r    <= motion_regs_pkg::RESET_POWER_ONE;
         pwrTwo_r    <= motion_regs_pkg::RESET_VALUE_ZERO;
         gyroXTrim_r <= '0;
         gyroYTrim_r <= '0;
         accX_r      <= '0;
         accY_r      <= '0;
         accZ_r      <= '0;
         rdData_r    <= motion_regs_pkg::RESET_VALUE_ZERO;
         rdValid_r   <= 1'b0;
         pop_r       <= 1'b0;
         push_r      <= 1'b0;
         pushData_r  <= motion_regs_pkg::RESET_VALUE_ZERO;
      end else begin
         motion_r    <= motion_nxt;
         host_r      <= host_nxt;
         pwrOne_r    <= pwrOne_nxt;
         pwrTwo_r    <= pwrTwo_nxt;
         gyroXTrim_r <= gyroXTrim_nxt;
         gyroYTrim_r <= gyroYTrim_nxt;
         accX_r      <= accX_nxt;
         accY_r      <= accY_nxt;
         accZ_r      <= accZ_nxt;
         rdData_r    <= rdData_nxt;
         rdValid_r   <= rdValid_nxt;
         pop_r       <= pop_nxt;
         push_r      <= push_nxt;
         pushData_r  <= pushData_nxt;
      end
   end

   // ----------------------------------------
   // Gyro offset correction
   // ----------------------------------------
   // trim added before the output register
   gyro_trim_adder #(
      .WIDTH (motion_regs_pkg::GYRO_WIDTH)
   ) u_gyro_x (
      .clk         (clk),
      .rst_b       (rst_b),
      .sampleValid (gyroSampleValid),
      .rawValue    (gyroXRaw),
      .trimValue   (gyroXTrim_r),
      .outValue    (gyroXOut)
   );

   gyro_trim_adder #(
      .WIDTH (motion_regs_pkg::GYRO_WIDTH)
   ) u_gyro_y (
      .clk         (clk),
      .rst_b       (rst_b),
      .sampleValid (gyroSampleValid),
      .rawValue    (gyroYRaw),
      .trimValue   (gyroYTrim_r),
      .outValue    (gyroYOut)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign regReadData      = rdData_r;
   assign regReadValid     = rdValid_r;

   assign queuePop         = pop_r;
   assign queuePush        = push_r;
   assign queuePushData    = pushData_r;

   assign motionDetectCtrl = motion_r;
   assign hostCtrl         = host_r;
   assign powerOne         = pwrOne_r;
   assign powerTwo         = pwrTwo_r;

   assign sleepMode        = pwrOne_r[motion_regs_pkg::POWER_ONE_SLEEP_BIT];
   // factory codes as held in the store
   assign selftestCodes    = stIf.codes;

   assign accelXTrim       = accX_r;
   assign accelYTrim       = accY_r;
   assign accelZTrim       = accZ_r;
endmodule

// ===== verif/motion_bank_checker.sv
// Port-level assertions for the motion sensor register bank
`timescale 1ns/10ps
module motion_bank_checker (
   // Clock, reset and register access
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [7:0]  regWriteData,
   input wire logic [7:0]  regReadData,
   input wire logic        regReadValid,
   // Queue and control
   input wire logic [12:0] queueLevel,
   input wire logic        queuePop,
   input wire logic        queuePush,
   input wire logic [7:0]  queuePushData,
   input wire logic [7:0]  hostCtrl,
   input wire logic [7:0]  powerOne,
   input wire logic        sleepMode,
   input wire logic [14:0] accelZTrim
);
   logic softPend_r;
   logic softPend_nxt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Writes in the edge after a soft reset are lost, so they are excluded
   always_comb begin
      softPend_nxt = regWrite && regAddr == 8'h6b && regWriteData[7];
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         softPend_r <= 1'b0;
      end else begin
         softPend_r <= softPend_nxt;
      end
   end
   sequence softWrite;
      regWrite && regAddr == 8'h6b && regWriteData[7] && !softPend_r;
   endsequence
   sequence bankRestored;
      ##2 powerOne == 8'h40 && hostCtrl == 8'h00 && sleepMode;
   endsequence
   a_read_answer: assert property (regRead |=> regReadValid)
      else $error("read not answered");
   a_valid_cause: assert property (regReadValid |-> $past(regRead))
      else $error("valid without read");
   a_level_high: assert property (regRead && regAddr == 8'h72 |=>
      regReadData == {3'h0, $past(queueLevel[12:8])}) else $error("level high");
   a_level_low: assert property (regRead && regAddr == 8'h73 |=>
      regReadData == $past(queueLevel[7:0])) else $error("level low");
   a_push_pulse: assert property (regWrite && regAddr == 8'h74 && !softPend_r |=>
      queuePush && queuePushData == $past(regWriteData)) else $error("push");
   a_pop_pulse: assert property (regRead && regAddr == 8'h74 |=> queuePop)
      else $error("pop");
   a_power_write: assert property (regWrite && regAddr == 8'h6b && !regWriteData[7]
      && !softPend_r |=> powerOne == $past(regWriteData) && sleepMode == $past(regWriteData[6]))
      else $error("power write");
   a_soft_restore: assert property (softWrite |-> bankRestored)
      else $error("soft reset");
   a_accel_pack: assert property (regWrite && regAddr == 8'h7e && !softPend_r |=>
      accelZTrim[6:0] == $past(regWriteData[7:1])) else $error("accel low pack");
   a_ctrl_hold: assert property (!(regWrite && regAddr == 8'h6a) && !softPend_r
      |=> $stable(hostCtrl)) else $error("control changed");
endmodule
bind motion_sensor_register_bank motion_bank_checker chk (.clk(clk), .rst_b(rst_b),
   .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
   .regReadData(regReadData), .regReadValid(regReadValid), .queueLevel(queueLevel),
   .queuePop(queuePop), .queuePush(queuePush), .queuePushData(queuePushData),
   .hostCtrl(hostCtrl), .powerOne(powerOne), .sleepMode(sleepMode), .accelZTrim(accelZTrim));

// ===== verif/host_model.sv
// Host processor model issuing single-byte register accesses
`timescale 1ns/10ps
module host_model (
   // Clock
   input  wire logic       clk,
   // Register access
   output logic      [7:0] regAddr,
   output logic            regWrite,
   output logic            regRead,
   output logic      [7:0] regWriteData,
   input  wire logic [7:0] regReadData,
   input  wire logic       regReadValid
);
   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWriteData = 8'h00;
   end
   // one byte per access; released lines flip so stale values never help
   task automatic release_bus;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = ~regAddr;
      regWriteData = ~regWriteData;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      @(posedge clk);
      #2;
      release_bus();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk);
      #2;
      regAddr = a;
      regRead = 1'b1;
      @(posedge clk);
      #2;
      release_bus();
      for (int n = 0; n < 4 && !ok; n++) begin
         if (regReadValid === 1'b1) begin
            ok = 1'b1;
            d = regReadData;
         end else begin
            @(posedge clk) #2;
         end
      end
   endtask
   // stored code to factory self-test measurement in lsb
   function automatic real factory_lsb(input logic [7:0] code, input int fullScaleSetting);
      return (2620.0 / (2.0 ** fullScaleSetting)) * (1.01 ** (real'(code) - 1.0));
   endfunction
endmodule

// ===== verif/motion_sensor_register_bank_bench.sv
// Self-checking bench for the motion sensor register bank
`timescale 1ns/10ps
module motion_sensor_register_bank_bench;
   localparam logic [7:0]  ID = 8'h3c;  // Arbitrary identity value
   localparam logic [47:0] FAC = 48'h9a8b7c6d5e4f;
   localparam logic [7:0]  MAP [24] = '{8'h00, 8'h01, 8'h02, 8'h0d, 8'h0e, 8'h0f, 8'h13,
      8'h14, 8'h15, 8'h16, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h72, 8'h73, 8'h74, 8'h75, 8'h77,
      8'h78, 8'h7a, 8'h7b, 8'h7d, 8'h7e};
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  regAddr, regWriteData, regReadData, queueReadData, queuePushData;
   logic [7:0]  motionDetectCtrl, hostCtrl, powerOne, powerTwo;
   logic        regWrite, regRead, regReadValid, queuePop, queuePush, gyroSampleValid;
   logic        sleepMode;
   logic [12:0] queueLevel;
   logic [15:0] gyroXRaw, gyroYRaw, gyroXOut, gyroYOut;
   logic [14:0] accelXTrim, accelYTrim, accelZTrim;
   logic [47:0] factoryCodes, selftestCodes;
   int          error_cnt = 0;
   int          total_checks = 0;
   always #12.5 clk = ~clk;
   host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid));
   motion_sensor_register_bank #(.DEVICE_ID(ID)) uut (.clk(clk), .rst_b(rst_b),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
      .regReadData(regReadData), .regReadValid(regReadValid), .factoryCodes(factoryCodes),
      .queueLevel(queueLevel), .queueReadData(queueReadData), .queuePop(queuePop),
      .queuePush(queuePush), .queuePushData(queuePushData), .gyroSampleValid(gyroSampleValid),
      .gyroXRaw(gyroXRaw), .gyroYRaw(gyroYRaw), .gyroXOut(gyroXOut), .gyroYOut(gyroYOut),
      .motionDetectCtrl(motionDetectCtrl), .hostCtrl(hostCtrl), .powerOne(powerOne),
      .powerTwo(powerTwo), .sleepMode(sleepMode), .selftestCodes(selftestCodes),
      .accelXTrim(accelXTrim), .accelYTrim(accelYTrim), .accelZTrim(accelZTrim));
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: no read answer", $time);
         finish_test();
      end
      check(d, e);
   endtask
   function automatic logic [7:0] rst_exp(input logic [7:0] a);
      case (a)
         8'h00, 8'h01, 8'h02: rst_exp = FAC[a[1:0]*8 +: 8];
         8'h0d, 8'h0e, 8'h0f: rst_exp = FAC[(a[1:0]+2)*8 +: 8];
         8'h6b: rst_exp = 8'h40;
         8'h75: rst_exp = ID;
         default: rst_exp = 8'h00;
      endcase
   endfunction
   task automatic t_reset_values;
      check(powerOne, 8'h40);
      check(sleepMode, 1'b1);
      foreach (MAP[i]) expect_rd(MAP[i], rst_exp(MAP[i]));
   endtask
   task automatic t_read_write;
      logic [7:0] a;
      foreach (MAP[i]) begin
         a = MAP[i];
         if (!(a inside {8'h6b, 8'h72, 8'h73, 8'h74, 8'h75})) begin
            host.wr(a, a ^ 8'h5a);
            expect_rd(a, (a ^ 8'h5a) & ((a inside {8'h78, 8'h7b, 8'h7e}) ? 8'hfe : 8'hff));
         end
      end
      check(hostCtrl, 8'h6a ^ 8'h5a);
      check(selftestCodes[7:0], 8'h5a);
      check(accelXTrim, {8'h77 ^ 8'h5a, 7'h11});
      check(accelYTrim, {8'h7a ^ 8'h5a, 7'h10});
      check(motionDetectCtrl, 8'h69 ^ 8'h5a);
      check(powerTwo, 8'h6c ^ 8'h5a);
      check(sleepMode, 1'b1);
      host.wr(8'h6b, 8'h01);
      check(powerOne, 8'h01);
      check(sleepMode, 1'b0);
   endtask
   task automatic t_read_only;
      logic [7:0] ro [4] = '{8'h72, 8'h73, 8'h75, 8'h20};
      queueLevel = 13'h1abc;
      foreach (ro[i]) host.wr(ro[i], 8'hff);
      expect_rd(8'h72, 8'h1a);
      expect_rd(8'h73, 8'hbc);
      expect_rd(8'h75, ID);
      expect_rd(8'h20, 8'h00);
      queueReadData = 8'hc3;
      host.wr(8'h74, 8'ha5);
      check(queuePush, 1'b1);
      check(queuePushData, 8'ha5);
      expect_rd(8'h74, 8'hc3);
   endtask
   task automatic t_gyro_trim;
      host.wr(8'h13, 8'hff);
      host.wr(8'h14, 8'hf0);
      host.wr(8'h15, 8'h00);
      host.wr(8'h16, 8'h20);
      gyroXRaw = 16'h0010;
      gyroYRaw = 16'h7ff0;
      gyroSampleValid = 1'b1;
      @(posedge clk);
      #2;
      gyroSampleValid = 1'b0;
      gyroXRaw = 16'h5555;
      check(gyroXOut, 16'h0000);
      check(gyroYOut, 16'h8010);
      @(posedge clk);
      #2;
      check(gyroXOut, 16'h0000);
   endtask
   task automatic t_soft_reset;
      host.wr(8'h6a, 8'h55);
      host.wr(8'h6b, 8'h80);
      @(posedge clk);
      #2;
      check(powerOne, 8'h40);
      check(sleepMode, 1'b1);
      check(hostCtrl, 8'h00);
      check(powerTwo, 8'h00);
      check(accelYTrim, 15'h0000);
      expect_rd(8'h13, 8'h00);
      expect_rd(8'h00, 8'h5a);
   endtask
   initial begin
      factoryCodes = FAC;
      queueLevel = 13'h0000;
      queueReadData = 8'h00;
      gyroSampleValid = 1'b0;
      gyroXRaw = 16'h0000;
      gyroYRaw = 16'h0000;
      repeat (6) @(posedge clk);
      #2;
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      t_reset_values();
      t_read_write();
      t_read_only();
      t_gyro_trim();
      t_soft_reset();
      finish_test();
   end
endmodule
